//--- core/acr_core.sv
// converter control: reference/channel select, gain, result formatting, apb slave
// Behaviour
// [R1] results land in the low/high result bytes in the same edge the done flag sets.
// [R2] single-ended result is vin*1024/vref, unsigned 0x000..0x3FF.
// [R3] unipolar differential is diff*1024/vref*gain, clamped 0..0x3FF, negative gives zero.
// [R4] bipolar differential is diff*512/vref*gain as 10-bit two's complement 0x200..0x1FF.
// [R5] differential conversions use gain one or twenty only.
// [R6] bipolar sign sits in the top result bit inside the high result byte.
// [R7] unipolar after reset, bipolar when software sets the bipolar select bit.
// [R8] channel code 100010 enables the temperature sensor as single-ended input.
// [R9] software must use the internal reference and single conversions for temperature.
// [R10] reference field 0 selects supply, 1 external pin, 2 internal, 3 reserved.
// [R11] a reference change written mid-conversion waits until that conversion is done.
// [R12] the conversion after a reference change is a long 25-cycle conversion.
// [R13] software should force a long conversion or discard results after changes.
// [R14] full result reads as high byte shifted left eight ORed with low byte.
// [R15] for differential channels the lowest channel bit picks gain one or twenty.
// [R16] a normal conversion takes 13 converter cycles, a long one 25.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module acr_core
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [11:0] sampleMv,
  input wire logic [11:0] vrefMv,
  output logic [1:0] refSelect,
  output logic [5:0] muxSelect,
  output logic tempSensorEn,
  output logic sampleHold
);
  // settled sample is treated as same-clock analog front-end data
  logic [7:0] chrefReg_ff;
  acr_pkg::acr_chref_s active_ff;
  logic bipolar_ff;
  logic enable_ff;
  logic done_ff;
  logic longNext_ff;
  logic [9:0] result_ff;
  logic [3:0] div_ff;
  logic [5:0] cyc_ff;
  logic [5:0] target_ff;
  acr_pkg::acr_state_e state_ff;
  acr_pkg::acr_state_e nxt_state;
  logic wrEn;
  logic adcTick;
  logic convEnd;
  logic startReq;

  function automatic logic is_diff(input logic [5:0] ch);
    is_diff = (ch[5:3] == 3'h1) || (ch[5:4] == 2'h1) || (ch[5:3] == 3'h5)
      || (ch[5:4] == 2'h3) || (ch[5:3] == 3'h4 && ch[2:0] >= 3'h3);
  endfunction

  function automatic logic [9:0] format_res(input logic [5:0] ch, input logic bip,
    input logic signed [11:0] vin, input logic [11:0] vr);
    logic signed [31:0] num;
    logic signed [31:0] q;
    logic signed [31:0] den;
    logic signed [31:0] gain;
    logic signed [31:0] full;
    // all operands signed, else a negative difference divides as unsigned
    num = 32'sd0;
    q = 32'sd0;
    den = $signed({20'h0, vr});
    gain = ch[0] ? $signed({27'h0, acr_pkg::GAIN_HI}) : 32'sd1; // [R15]
    full = $signed({21'h0, acr_pkg::FULL_SCALE});
    if (vr == 12'h000)
      format_res = 10'h000;
    else if (!is_diff(ch))
    begin
      num = (vin < 0) ? 32'sd0 : 32'(vin) * full; // [R2] [R8]
      q = num / den;
      format_res = (q > 32'sd1023) ? 10'h3FF : q[9:0];
    end
    else
    begin
      num = 32'(vin) * gain; // [R5] [R15]
      if (bip)
      begin
        q = (num * 32'sd512) / den; // [R4] [R6]
        format_res = (q > 32'sd511) ? 10'h1FF : (q < -32'sd512) ? 10'h200 : q[9:0];
      end
      else
      begin
        q = (num * full) / den; // [R3]
        format_res = (q < 32'sd0) ? 10'h000 : (q > 32'sd1023) ? 10'h3FF : q[9:0];
      end
    end
  endfunction

  assign wrEn = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign adcTick = (div_ff == acr_pkg::ADC_DIV - 4'h1);
  assign convEnd = (state_ff == acr_pkg::ACR_CONV) && adcTick && (cyc_ff == target_ff - 6'h01);
  assign startReq = wrEn && (paddr == acr_pkg::ADDR_CMD) && pwdata[acr_pkg::CMD_START_POS];

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      chrefReg_ff <= acr_pkg::CHREF_RESET;
    else if (wrEn && paddr == acr_pkg::ADDR_CHREF)
      chrefReg_ff <= pwdata[7:0];
  end

  // register copy applies only between conversions
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      active_ff <= acr_pkg::acr_chref_s'(acr_pkg::CHREF_RESET);
    else if (state_ff == acr_pkg::ACR_IDLE || convEnd)
      active_ff <= acr_pkg::acr_chref_s'(chrefReg_ff); // [R11]
  end

  // reference change, or re-enable, arms the next conversion as long
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      longNext_ff <= 1'b1;
    else if ((state_ff == acr_pkg::ACR_IDLE || convEnd)
      && chrefReg_ff[7:6] != active_ff.refSel)
      longNext_ff <= 1'b1; // [R12]
    else if (!enable_ff)
      longNext_ff <= 1'b1;
    else if (state_ff == acr_pkg::ACR_IDLE && startReq)
      longNext_ff <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bipolar_ff <= 1'b0; // [R7]
    end
    else if (wrEn && paddr == acr_pkg::ADDR_CTRLB)
    begin
      bipolar_ff <= pwdata[acr_pkg::BIPOLAR_POS]; // [R7]
    end
  end

  // clearing enable abandons a running conversion, no result written unless its last converter cycle ends in the cycle enable reads low
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      enable_ff <= 1'b0;
    else if (wrEn && paddr == acr_pkg::ADDR_CMD)
      enable_ff <= pwdata[acr_pkg::CMD_EN_POS];
  end

  // divider held while idle, so every start is phase aligned
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      div_ff <= 4'h0;
    else if (state_ff == acr_pkg::ACR_IDLE || adcTick)
      div_ff <= 4'h0;
    else
      div_ff <= div_ff + 4'h1;
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      acr_pkg::ACR_IDLE:
        if (startReq && enable_ff)
          nxt_state = acr_pkg::ACR_CONV;
      acr_pkg::ACR_CONV:
        if (!enable_ff || convEnd)
          nxt_state = acr_pkg::ACR_IDLE;
      default:
        nxt_state = acr_pkg::ACR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      state_ff <= acr_pkg::ACR_IDLE;
    else
      state_ff <= nxt_state;
  end

  // length latched at start, a later write cannot stretch a running conversion
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cyc_ff <= 6'h00;
      target_ff <= acr_pkg::NORMAL_CYC;
    end
    else if (state_ff == acr_pkg::ACR_IDLE)
    begin
      cyc_ff <= 6'h00;
      target_ff <= longNext_ff ? acr_pkg::LONG_CYC : acr_pkg::NORMAL_CYC; // [R16]
    end
    else if (adcTick)
      cyc_ff <= cyc_ff + 6'h01;
  end

  // set beats a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      done_ff <= 1'b0;
    else if (convEnd)
      done_ff <= 1'b1; // [R1]
    else if (wrEn && paddr == acr_pkg::ADDR_STAT && pwdata[acr_pkg::DONE_POS])
      done_ff <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      result_ff <= 10'h000;
    else if (convEnd)
      result_ff <= format_res(active_ff.chan, bipolar_ff, sampleMv, vrefMv); // [R1]
  end

  // loaded in the setup cycle so it stands through the whole access phase
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        acr_pkg::ADDR_CHREF: prdata <= {24'h00_0000, chrefReg_ff};
        acr_pkg::ADDR_CTRLB: prdata <= {24'h00_0000, bipolar_ff, 7'h00};
        acr_pkg::ADDR_STAT: prdata <= {30'h0000_0000, state_ff == acr_pkg::ACR_CONV, done_ff};
        acr_pkg::ADDR_RESLO: prdata <= {24'h00_0000, result_ff[7:0]}; // [R14]
        acr_pkg::ADDR_RESHI: prdata <= {30'h0000_0000, result_ff[9:8]}; // [R6] [R14]
        acr_pkg::ADDR_CMD: prdata <= {31'h0000_0000, enable_ff};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      refSelect <= acr_pkg::REF_VCC;
      muxSelect <= 6'h00;
      tempSensorEn <= 1'b0;
      sampleHold <= 1'b0;
    end
    else
    begin
      // reserved code falls back to the supply rather than an open input
      refSelect <= (active_ff.refSel == 2'h3) ? acr_pkg::REF_VCC : active_ff.refSel; // [R10]
      muxSelect <= active_ff.chan;
      tempSensorEn <= (active_ff.chan == acr_pkg::TEMP_CH); // [R8]
      sampleHold <= (state_ff == acr_pkg::ACR_CONV);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  done_with_result_a: assert property (convEnd // [R1]
    |=> done_ff && result_ff == $past(format_res(active_ff.chan, bipolar_ff,
    sampleMv, vrefMv))) else $error("result not ready with done");
  ref_defer_a: assert property (state_ff == acr_pkg::ACR_CONV && !convEnd |=> // [R11]
    active_ff == $past(active_ff)) else $error("reference changed mid conversion");
  long_after_ref_a: assert property (state_ff == acr_pkg::ACR_IDLE // [R12]
    && chrefReg_ff[7:6] != active_ff.refSel |=> longNext_ff) else $error("no long conversion");
  conv_len_a: assert property (state_ff == acr_pkg::ACR_IDLE && startReq && enable_ff // [R16]
    |=> target_ff == ($past(longNext_ff) ? acr_pkg::LONG_CYC : acr_pkg::NORMAL_CYC))
    else $error("bad conversion length");
  ref_decode_a: assert property (refSelect != 2'h3) // [R10]
    else $error("reserved reference driven");
  temp_en_a: assert property (active_ff.chan == acr_pkg::TEMP_CH |=> tempSensorEn) // [R8]
    else $error("temperature sensor not enabled");
  temp_mux_a: assert property (tempSensorEn |-> muxSelect == acr_pkg::TEMP_CH) // [R8]
    else $error("temperature sensor on for another channel");
  done_clear_a: assert property (!convEnd && wrEn && paddr == acr_pkg::ADDR_STAT // [R1]
    && pwdata[acr_pkg::DONE_POS] |=> !done_ff) else $error("done flag not cleared");
  unipolar_clamp_a: assert property (convEnd && !bipolar_ff && is_diff(active_ff.chan) // [R3]
    && sampleMv < 0 |=> result_ff == 10'h000) else $error("negative not clamped");
  bipolar_sign_a: assert property (convEnd && bipolar_ff && is_diff(active_ff.chan) // [R6]
    && sampleMv < 0 && vrefMv != 12'h000 && active_ff.chan[0] |=> result_ff[9])
    else $error("sign bit wrong");
  single_range_a: assert property (convEnd && !is_diff(active_ff.chan) && sampleMv >= 0 // [R2]
    && 32'(sampleMv) >= 32'(vrefMv) && vrefMv != 12'h000 |=> result_ff == 10'h3FF)
    else $error("single-ended not saturated");
  bip_reset_a: assert property ($rose(nrst) |-> !bipolar_ff) else $error("not unipolar"); // [R7]

  conv_done_c: cover property (convEnd);
  long_conv_c: cover property (convEnd && target_ff == acr_pkg::LONG_CYC);
  bipolar_neg_c: cover property (convEnd && bipolar_ff && sampleMv < 0);
  temp_c: cover property (convEnd && tempSensorEn);
  mid_ref_c: cover property (state_ff == acr_pkg::ACR_CONV && wrEn
    && paddr == acr_pkg::ADDR_CHREF);
endmodule

//--- core/acr_pkg.sv
// package: register map, field layout and timing for the converter result block
package acr_pkg;
  localparam logic [7:0] CHREF_IDX = 8'h07;    // channel_reference_select word index
  localparam logic [7:0] ADDR_CHREF = {CHREF_IDX[5:0], 2'h0};
  localparam logic [7:0] ADDR_CTRLB = 8'h20;   // converter_control_b
  localparam logic [7:0] ADDR_STAT = 8'h24;    // conversion_done_flag etc.
  localparam logic [7:0] ADDR_RESLO = 8'h28;   // result_low_byte
  localparam logic [7:0] ADDR_RESHI = 8'h2C;   // result_high_byte
  localparam logic [7:0] ADDR_CMD = 8'h30;     // start / enable
  localparam logic [7:0] CHREF_RESET = 8'h00;
  localparam int REF_HI_POS = 7;
  localparam int REF_LO_POS = 6;
  localparam int BIPOLAR_POS = 7;
  localparam int DONE_POS = 0;
  localparam int BUSY_POS = 1;
  localparam int CMD_EN_POS = 0;
  localparam int CMD_START_POS = 1;
  localparam logic [5:0] TEMP_CH = 6'h22;
  localparam logic [1:0] REF_VCC = 2'h0;
  localparam logic [1:0] REF_EXT = 2'h1;
  localparam logic [1:0] REF_INT = 2'h2;
  localparam logic [5:0] NORMAL_CYC = 6'h0D;
  localparam logic [5:0] LONG_CYC = 6'h19;
  localparam logic [4:0] GAIN_HI = 5'h14;
  localparam logic [3:0] ADC_DIV = 4'h4;       // converter clock = ref_clk / 4
  localparam logic [10:0] FULL_SCALE = 11'h400;
  typedef enum logic [1:0] {ACR_IDLE, ACR_CONV} acr_state_e;
  typedef struct packed {
    logic [1:0] refSel;
    logic [5:0] chan;
  } acr_chref_s;
endpackage

//--- tb/acr_core_test.sv
// testbench: apb access, conversion length and result format of the converter block
`timescale 1ns/1ps
module acr_core_test;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, tempSensorEn, sampleHold, bipMode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [11:0] sampleMv;
  logic [11:0] vrefMv;
  logic [1:0] refSelect;
  logic [5:0] muxSelect, lastCh;
  int err_total = 0, n_tests = 0, seed = 32'hCE67, holdCnt, lastRef, refV, r;
  logic [5:0] chans [8] = '{6'h00, 6'h05, 6'h08, 6'h09, 6'h22, 6'h23, 6'h2B, 6'h3E};
  acr_core u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampleMv(sampleMv), .vrefMv(vrefMv), .refSelect(refSelect),
    .muxSelect(muxSelect), .tempSensorEn(tempSensorEn), .sampleHold(sampleHold));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (sampleHold === 1'b1) holdCnt++;
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until pready is seen high; the watchdog ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function logic [9:0] expRes(input int s, input int v, input logic [5:0] ch, input logic bip);
    int g, x;
    logic dif;
    dif = ch >= 6'h08 && ch != 6'h20 && ch != 6'h21 && ch != 6'h22;
    g = (dif && ch[0]) ? 20 : 1;
    if (v == 0) return 10'h000;
    if (dif && bip)
    begin
      x = s * 512 * g / v;
      x = (x > 511) ? 511 : (x < -512) ? -512 : x;
    end
    else
    begin
      x = s * 1024 * g / v;
      x = (x > 1023) ? 1023 : (x < 0) ? 0 : x;
    end
    return x[9:0];
  endfunction
  // mid: the select write lands while the conversion runs
  task conv(input logic [7:0] cr, input bit mid, input bit lng);
    logic [31:0] lo;
    logic [9:0] e;
    bit seen;
    int k;
    seen = 0;
    if (!mid) apb(1'b1, acr_pkg::ADDR_CHREF, {24'h0, cr});
    holdCnt = 0;
    apb(1'b1, acr_pkg::ADDR_CMD, 32'h3);
    if (mid)
    begin
      apb(1'b1, acr_pkg::ADDR_CHREF, {24'h0, cr});
      // a few edges later, so an undeferred update would already show
      apb(1'b0, acr_pkg::ADDR_STAT, 32'h0);
      chk("busy", rd[acr_pkg::BUSY_POS], 1);
      chk("refHeld", {30'h0, refSelect}, lastRef);
    end
    do
    begin
      @(posedge ref_clk);
      if (sampleHold === 1'b1) seen = 1;
    end
    while (!(seen && sampleHold === 1'b0));
    k = (lng ? acr_pkg::LONG_CYC : acr_pkg::NORMAL_CYC) * acr_pkg::ADC_DIV;
    chk("convLen", holdCnt >= k - 1 && holdCnt <= k + 1, 1);
    apb(1'b0, acr_pkg::ADDR_STAT, 32'h0);
    chk("done", rd[acr_pkg::DONE_POS], 1);
    apb(1'b0, acr_pkg::ADDR_RESLO, 32'h0);
    lo = rd;
    apb(1'b0, acr_pkg::ADDR_RESHI, 32'h0);
    e = expRes(sampleMv, vrefMv, cr[5:0], bipMode);
    chk("result", (rd << 8) | lo, {22'h0, e});
    chk("signBit", rd[1], e[9]);
    chk("refApplied", refSelect, (cr[7:6] == 2'h3) ? 2'h0 : cr[7:6]);
    chk("chanApplied", muxSelect, cr[5:0]);
    chk("tempEn", tempSensorEn, cr[5:0] === acr_pkg::TEMP_CH);
    apb(1'b1, acr_pkg::ADDR_STAT, 32'h1);
    apb(1'b0, acr_pkg::ADDR_STAT, 32'h0);
    chk("doneClr", rd[acr_pkg::DONE_POS], 0);
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata, sampleMv, bipMode} = '0;
    vrefMv = 12'h400;
    lastRef = -1;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, acr_pkg::ADDR_CHREF, 32'h0);
    chk("chrefRst", rd, {24'h0, acr_pkg::CHREF_RESET});
    apb(1'b0, acr_pkg::ADDR_CTRLB, 32'h0);
    chk("bipRst", rd[acr_pkg::BIPOLAR_POS], 0);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("slvErr", pslverr, 0);
    apb(1'b1, acr_pkg::ADDR_CMD, 32'h1);
    // first three passes walk every legal reference code
    for (int i = 0; i < 14; i++)
    begin
      r = $random(seed);
      refV = (i < 3) ? i : (r[30:29] % 3);
      bipMode = r[8];
      lastCh = chans[r[15:13]];
      apb(1'b1, acr_pkg::ADDR_CTRLB, {24'h0, bipMode, 7'h0});
      // multiples of four keep every quotient exact
      sampleMv <= {r[11:2], 2'h0};
      vrefMv <= (i == 5) ? 12'h000 : r[12] ? 12'h400 : 12'h800;
      conv({refV[1:0], lastCh}, 1'b0, refV != lastRef);
      apb(1'b0, acr_pkg::ADDR_CHREF, 32'h0);
      chk("chrefRb", rd[7:0], {refV[1:0], lastCh});
      lastRef = refV;
    end
    refV = (lastRef == 2) ? 1 : 2;
    conv({refV[1:0], lastCh}, 1'b1, 1'b0);
    lastRef = refV;
    // the reference written mid-run above still makes this one long
    conv({2'h2, acr_pkg::TEMP_CH}, 1'b0, 1'b1);
    conv(8'hC5, 1'b0, 1'b1);
    apb(1'b1, acr_pkg::ADDR_CMD, 32'h0);
    apb(1'b1, acr_pkg::ADDR_CMD, 32'h1);
    conv(8'hC5, 1'b0, 1'b1);
    give_verdict();
  end
endmodule
